// ==== core/pwd_decoder_ctrl.v ====
/*
 * Digital control of a six-bit pcm-to-pam decoder: serial read-in,
 * parallel holding register, ladder clamp controls, half-level
 * matching, address digit removal, top-bit outputs, word tap FIFO.
 * Assumes every receive pin input is asynchronous to core_clk_in and slow
 * against it (bit clock at most a few MHz, core clock 40 MHz).
 */
// How it works
// - pcm words arrive as six serial bits into a six-stage shift register.
// - a readout event copies all six serial stages into the holding register.
// - the holding register keeps driving outputs while the next word shifts.
// - each held bit drives one clamp control: high means reference, low ground.
// - clamp controls are ordered by weight, most significant bit on top.
// - code 15 drops the first half-level correction from one to zero.
// - code 48 raises the second half-level correction from zero to one.
// - the last word of a frame loses its least significant bit.
// - top bit and next bit of the held word go out with complements.
// - the first stage is set by a one and cleared by a zero.
// - with in-frame high the first stage follows the incoming bits.
// - with in-frame low the first stage is frozen against line noise.
// - each shift happens on the trailing edge of a decoder clock pulse.
// - after five shifts the word sits with msb last, lsb first.
// - a variant select picks the high-traffic or the alternate readout path.
// - a timing output serves the high-traffic modem.
// - that timing output is the 384 kc word-rate readout signal.
// - transfer happens before the sixth shift, with the full word present.
// - while the 8 kc inhibit is active the lsb is cleared, not loaded.
// - first top-bit output is the msb, second the next bit.
`timescale 1ns/10ps
`default_nettype none

`include "pwd_defines.vh"

module pwd_decoder_ctrl (
	// clock and reset
	input  wire                    core_clk_in,
	input  wire                    rst_n_in,
	// receive section pins
	input  wire                    pcm_bit_in,
	input  wire                    dec_clk_n_in,
	input  wire                    in_frame_in,
	input  wire                    readout_in,
	input  wire                    addr_inhibit_n_in,
	// configuration
	input  wire                    variant_select_in,
	// word tap drain
	input  wire                    word_ready_in,
	input  wire                    overrun_clear_in,
	// ladder clamp controls
	output reg  [`PWD_WORD_W-1:0]  clamp_out,
	output reg                     clamp_msb_n_out,
	output reg                     half_dn_out,
	output reg                     half_up_out,
	// top-bit outputs
	output reg                     top_a_out,
	output reg                     top_a_n_out,
	output reg                     top_b_out,
	output reg                     top_b_n_out,
	// modem timing
	output reg                     word_rate_timing_out,
	// word tap
	output wire                    word_valid_out,
	output wire [`PWD_WORD_W-1:0]  word_out,
	output wire                    tap_ready_out,
	output reg                     overrun_out,
	// status
	output reg                     in_frame_out
);

////////////////////////////////////////////////////////////////////////
// variant select levels

localparam high_traffic_setting      = 1'b1;
localparam alternate_traffic_setting = 1'b0;

// readout path states
localparam RD_IDLE  = 2'b00;
localparam RD_DELAY = 2'b01;
localparam RD_FIRE  = 2'b10;

////////////////////////////////////////////////////////////////////////
// helpers

// decoded code match, used for both correction outputs
function match_code;
	input [`PWD_WORD_W-1:0] word;
	input [`PWD_WORD_W-1:0] code;
	begin
		match_code = (word == code);
	end
endfunction

// lsb gate for the address digit
function [`PWD_WORD_W-1:0] strip_addr;
	input [`PWD_WORD_W-1:0] word;
	input                   inhibit;
	begin
		strip_addr = word;
		if (inhibit) begin
			strip_addr[`PWD_LSB_POS] = 1'b0;
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////
// pin synchronisers

reg  [`PWD_SYN_W-1:0] syn_meta;
reg  [`PWD_SYN_W-1:0] syn_pin;
reg  [`PWD_SYN_W-1:0] syn_prev;
wire [`PWD_SYN_W-1:0] pin_rise;
wire [`PWD_SYN_W-1:0] pin_fall;

always @(posedge core_clk_in) begin
	if (!rst_n_in) begin
		syn_meta <= `PWD_SYN_RST;
		syn_pin  <= `PWD_SYN_RST;
		syn_prev <= `PWD_SYN_RST;
	end else begin
		syn_meta <= {addr_inhibit_n_in, readout_in, in_frame_in, pcm_bit_in, dec_clk_n_in};
		syn_pin  <= syn_meta;
		syn_prev <= syn_pin;
	end
end

// edges only from the second stage onward
assign pin_rise = syn_pin & ~syn_prev;
assign pin_fall = ~syn_pin & syn_prev;

wire dclk_trail;
wire pcm_edge;
wire frame_ok;
wire rdout_fall;
wire inhibit_now;

// clock pulses are negative-going, so the trailing edge is the rise
assign dclk_trail  = pin_rise[`PWD_SYN_DCLK];
assign pcm_edge    = pin_rise[`PWD_SYN_PCM] | pin_fall[`PWD_SYN_PCM];
assign frame_ok    = syn_pin[`PWD_SYN_FRAME];
assign rdout_fall  = pin_fall[`PWD_SYN_RDOUT];
assign inhibit_now = !syn_pin[`PWD_SYN_INH_N];

////////////////////////////////////////////////////////////////////////
// serial register

reg                   first_serial_stage;
reg [`PWD_WORD_W-1:1] serial_upper;
wire                  last_serial_stage;
wire [`PWD_WORD_W-1:0] serial_word;

assign serial_word       = {last_serial_stage, serial_upper[`PWD_WORD_W-2:1], first_serial_stage};
assign last_serial_stage = serial_upper[`PWD_MSB_POS];

always @(posedge core_clk_in) begin
	if (!rst_n_in) begin
		first_serial_stage <= 1'b0;
	end else if (frame_ok && pcm_edge) begin
		// a one sets, a zero clears; out of frame nothing gets in
		first_serial_stage <= syn_pin[`PWD_SYN_PCM];
	end
end

// shift takes the first stage as it was before any same-cycle bit edge
always @(posedge core_clk_in) begin
	if (!rst_n_in) begin
		serial_upper <= `PWD_UPPER_RST;
	end else if (dclk_trail) begin
		serial_upper <= {serial_upper[`PWD_WORD_W-2:1], first_serial_stage};
	end
end

////////////////////////////////////////////////////////////////////////
// readout path: high traffic waits a fixed delay after the falling
// edge, alternate fires in the cycle after the edge

reg [1:0]             rd_state;
reg [1:0]             next_rd_state;
reg [`PWD_DLY_W-1:0]  rd_count;
reg [`PWD_DLY_W-1:0]  next_rd_count;
reg                   xfer;

always @* begin
	next_rd_state = rd_state;
	next_rd_count = rd_count;
	xfer          = 1'b0;
	case (rd_state)
		RD_IDLE: begin
			if (rdout_fall) begin
				if (variant_select_in == high_traffic_setting) begin
					next_rd_count = `PWD_HT_DELAY_CYC;
					next_rd_state = RD_DELAY;
				end else begin
					next_rd_state = RD_FIRE;
				end
			end
		end
		RD_DELAY: begin
			if (rd_count <= {{(`PWD_DLY_W-1){1'b0}}, 1'b1}) begin
				next_rd_state = RD_FIRE;
			end else begin
				next_rd_count = rd_count - 1'b1;
			end
		end
		RD_FIRE: begin
			xfer          = 1'b1;
			next_rd_state = RD_IDLE;
		end
		default: begin
			next_rd_state = RD_IDLE;
		end
	endcase
end

always @(posedge core_clk_in) begin
	if (!rst_n_in) begin
		rd_state <= RD_IDLE;
		rd_count <= {`PWD_DLY_W{1'b0}};
	end else begin
		rd_state <= next_rd_state;
		rd_count <= next_rd_count;
	end
end

////////////////////////////////////////////////////////////////////////
// parallel holding register and converter controls

reg  [`PWD_WORD_W-1:0] hold_word;
wire [`PWD_WORD_W-1:0] next_hold_word;

// the full word is present since readout lands before the sixth shift
assign next_hold_word = strip_addr(serial_word, inhibit_now);

always @(posedge core_clk_in) begin
	if (!rst_n_in) begin
		hold_word       <= `PWD_WORD_RST;
		clamp_out       <= `PWD_WORD_RST;
		clamp_msb_n_out <= 1'b1;
		half_dn_out     <= `PWD_HALF_DN_RST;
		half_up_out     <= `PWD_HALF_UP_RST;
		top_a_out       <= 1'b0;
		top_a_n_out     <= 1'b1;
		top_b_out       <= 1'b0;
		top_b_n_out     <= 1'b1;
	end else if (xfer) begin
		// everything below only moves here, so it stands for a whole word
		hold_word       <= next_hold_word;
		clamp_out       <= next_hold_word;
		clamp_msb_n_out <= !next_hold_word[`PWD_MSB_POS];
		half_dn_out     <= !match_code(next_hold_word, `PWD_CODE_SUB_HALF);
		half_up_out     <= match_code(next_hold_word, `PWD_CODE_ADD_HALF);
		top_a_out       <= next_hold_word[`PWD_MSB_POS];
		top_a_n_out     <= !next_hold_word[`PWD_MSB_POS];
		top_b_out       <= next_hold_word[`PWD_NMSB_POS];
		top_b_n_out     <= !next_hold_word[`PWD_NMSB_POS];
	end
end

////////////////////////////////////////////////////////////////////////
// modem timing and status

always @(posedge core_clk_in) begin
	if (!rst_n_in) begin
		word_rate_timing_out <= 1'b0;
		in_frame_out         <= 1'b0;
	end else begin
		word_rate_timing_out <= syn_pin[`PWD_SYN_RDOUT];
		in_frame_out         <= frame_ok;
	end
end

////////////////////////////////////////////////////////////////////////
// word tap: each held word is offered to a consumer through the FIFO;
// a stalled consumer loses words, which shows on the overrun flag,
// because the ladder timing cannot wait for it

wire tap_ready;
wire tap_push;

assign tap_push      = xfer;
assign tap_ready_out = tap_ready;

pwd_fifo #(
	.WIDTH (`PWD_WORD_W),
	.DEPTH (`PWD_FIFO_DEPTH),
	.AW    (`PWD_FIFO_AW)
) u_tap_fifo (
	.core_clk_in   (core_clk_in),
	.rst_n_in      (rst_n_in),
	.in_valid_in   (tap_push),
	.in_data_in    (next_hold_word),
	.in_ready_out  (tap_ready),
	.out_valid_out (word_valid_out),
	.out_data_out  (word_out),
	.out_ready_in  (word_ready_in),
	.full_out      (),
	.empty_out     ()
);

// a lost word in the clearing cycle keeps the flag set
always @(posedge core_clk_in) begin
	if (!rst_n_in) begin
		overrun_out <= 1'b0;
	end else if (tap_push && !tap_ready) begin
		overrun_out <= 1'b1;
	end else if (overrun_clear_in) begin
		overrun_out <= 1'b0;
	end
end

endmodule // pwd_decoder_ctrl

`default_nettype wire

// ==== core/pwd_defines.vh ====
/*
 * Constants for the pcm word decoder control: word layout, codes,
 * reset values and timing counts.
 * Assumes a 40 MHz core clock; included by bare name.
 */
`ifndef PWD_DEFINES_VH
`define PWD_DEFINES_VH

// word layout
`define PWD_WORD_W          6
`define PWD_MSB_POS         5
`define PWD_NMSB_POS        4
`define PWD_LSB_POS         0

// codes that need half-level matching
`define PWD_CODE_SUB_HALF   6'h0f
`define PWD_CODE_ADD_HALF   6'h30

// reset values
`define PWD_WORD_RST        6'h00
`define PWD_HALF_DN_RST     1'b1
`define PWD_HALF_UP_RST     1'b0
`define PWD_UPPER_RST       5'h00
// idle pin levels, so leaving reset shows no false edge
`define PWD_SYN_RST         5'h19

// buffer shape
`define PWD_FIFO_DEPTH      8
`define PWD_FIFO_AW         3

// pin sync vector positions
`define PWD_SYN_W           5
`define PWD_SYN_DCLK        0
`define PWD_SYN_PCM         1
`define PWD_SYN_FRAME       2
`define PWD_SYN_RDOUT       3
`define PWD_SYN_INH_N       4

// timing
// high-traffic one-shot delay: 100 ns of a 40 MHz clock
`define PWD_HT_DELAY_CYC    4'h4
`define PWD_DLY_W           4

`endif

// ==== core/pwd_fifo.v ====
/*
 * Word FIFO with valid/ready on both sides and a registered read port.
 * Assumes same-clock producer and consumer; synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module pwd_fifo #(
	parameter WIDTH = 6,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// clock and reset
	input  wire             core_clk_in,
	input  wire             rst_n_in,
	// filling side
	input  wire             in_valid_in,
	input  wire [WIDTH-1:0] in_data_in,
	output wire             in_ready_out,
	// draining side
	output reg              out_valid_out,
	output reg  [WIDTH-1:0] out_data_out,
	input  wire             out_ready_in,
	// status
	output wire             full_out,
	output wire             empty_out
);

////////////////////////////////////////////////////////////////////////

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0]    wr_ptr;
reg [AW-1:0]    rd_ptr;
reg [AW:0]      mem_cnt;
wire            push;
wire            pop;

assign full_out     = (mem_cnt == DEPTH[AW:0]);
assign in_ready_out = !full_out;
assign empty_out    = (mem_cnt == {(AW+1){1'b0}}) && !out_valid_out;
assign push         = in_valid_in && in_ready_out;
// refill the output register when it is empty or being taken
assign pop          = (mem_cnt != {(AW+1){1'b0}}) && (!out_valid_out || out_ready_in);

////////////////////////////////////////////////////////////////////////

always @(posedge core_clk_in) begin
	if (push) begin
		mem[wr_ptr] <= in_data_in;
	end
end

always @(posedge core_clk_in) begin
	if (!rst_n_in) begin
		wr_ptr        <= {AW{1'b0}};
		rd_ptr        <= {AW{1'b0}};
		mem_cnt       <= {(AW+1){1'b0}};
		out_valid_out <= 1'b0;
		out_data_out  <= {WIDTH{1'b0}};
	end else begin
		if (push) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
		if (pop) begin
			rd_ptr        <= rd_ptr + 1'b1;
			out_data_out  <= mem[rd_ptr];
			out_valid_out <= 1'b1;
		end else if (out_ready_in) begin
			out_valid_out <= 1'b0;
		end
		case ({push, pop})
			2'b10:   mem_cnt <= mem_cnt + 1'b1;
			2'b01:   mem_cnt <= mem_cnt - 1'b1;
			default: mem_cnt <= mem_cnt;
		endcase
	end
end

endmodule // pwd_fifo

`default_nettype wire

// ==== verif/pwd_decoder_ctrl_monitor.sv ====
/*
 * Concurrent checks on the decoder control ports: ladder controls,
 * half-level matching, top bits, transfer timing and the word tap.
 * Assumes the pin inputs are driven a little after the core clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pwd_defines.vh"

module pwd_ctrl_monitor (
	// clock and reset
	input wire logic                   core_clk_in,
	input wire logic                   rst_n_in,
	// inputs
	input wire logic                   addr_inhibit_n_in,
	input wire logic                   in_frame_in,
	input wire logic                   variant_select_in,
	input wire logic                   word_ready_in,
	// outputs
	input wire logic [`PWD_WORD_W-1:0] clamp_out,
	input wire logic                   clamp_msb_n_out,
	input wire logic                   half_dn_out,
	input wire logic                   half_up_out,
	input wire logic                   top_a_out,
	input wire logic                   top_a_n_out,
	input wire logic                   top_b_out,
	input wire logic                   top_b_n_out,
	input wire logic                   word_rate_timing_out,
	input wire logic                   word_valid_out,
	input wire logic [`PWD_WORD_W-1:0] word_out,
	input wire logic                   in_frame_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	////////////////////////////////////////////////////////////////
	// readout fall seen on the timing output, counted back from a transfer
	sequence ro_fell_alt;
		$past(word_rate_timing_out, 2) && !$past(word_rate_timing_out, 1);
	endsequence
	sequence ro_fell_ht;
		$past(word_rate_timing_out, 6) && !$past(word_rate_timing_out, 5);
	endsequence

	////////////////////////////////////////////////////////////////
	msb_compl_a: assert property (clamp_msb_n_out == !clamp_out[5])
		else $error("msb clamp pair not complementary");
	half_down_a: assert property (half_dn_out == (clamp_out != 6'h0f))
		else $error("lower half-level control wrong for held word");
	half_up_a: assert property (half_up_out == (clamp_out == 6'h30))
		else $error("upper half-level control wrong for held word");
	top_bits_a: assert property ({top_a_out, top_a_n_out, top_b_out, top_b_n_out} ==
		{clamp_out[5], !clamp_out[5], clamp_out[4], !clamp_out[4]})
		else $error("top bit outputs disagree with held word");
	xfer_alt_a: assert property ($changed(clamp_out) && !variant_select_in |-> ro_fell_alt)
		else $error("held word changed off the alternate readout time");
	xfer_ht_a: assert property ($changed(clamp_out) && variant_select_in |-> ro_fell_ht)
		else $error("held word changed off the delayed readout time");
	lsb_strip_a: assert property ($changed(clamp_out) && !$past(addr_inhibit_n_in, 3) |-> !clamp_out[0])
		else $error("address digit reached the ladder");
	tap_match_a: assert property ($rose(word_valid_out) |-> word_out == clamp_out)
		else $error("tap word differs from held word");
	tap_hold_a: assert property (word_valid_out && !word_ready_in |=> word_valid_out && $stable(word_out))
		else $error("tap word moved while stalled");
	frame_sync_a: assert property ($changed(in_frame_out) |-> in_frame_out == $past(in_frame_in, 3))
		else $error("in-frame status follows the pin wrongly");
endmodule // pwd_ctrl_monitor

bind pwd_decoder_ctrl pwd_ctrl_monitor mon (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.addr_inhibit_n_in(addr_inhibit_n_in), .in_frame_in(in_frame_in), .variant_select_in(variant_select_in),
	.word_ready_in(word_ready_in), .clamp_out(clamp_out), .clamp_msb_n_out(clamp_msb_n_out),
	.half_dn_out(half_dn_out), .half_up_out(half_up_out), .top_a_out(top_a_out), .top_a_n_out(top_a_n_out),
	.top_b_out(top_b_out), .top_b_n_out(top_b_n_out), .word_rate_timing_out(word_rate_timing_out),
	.word_valid_out(word_valid_out), .word_out(word_out), .in_frame_out(in_frame_out));
`default_nettype wire

// ==== verif/pwd_rx_model.sv ====
/*
 * Receive section model: serial pcm bits, decoder clock, frame status,
 * readout and address inhibit pins.
 * Assumes the core clock; pins change one ns after its rising edge.
 */
`timescale 1ns/10ps
`default_nettype none

module pwd_rx_model (
	// clock
	input wire logic core_clk_in,
	// receive pins
	output logic     pcm_bit_out,
	output logic     dec_clk_n_out,
	output logic     in_frame_out,
	output logic     readout_out,
	output logic     inhibit_n_out
);
	initial begin
		pcm_bit_out = 1'b0;
		dec_clk_n_out = 1'b1;
		in_frame_out = 1'b0;
		readout_out = 1'b1;
		inhibit_n_out = 1'b1;
	end

	task automatic step(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask

	////////////////////////////////////////////////////////////////
	// msb first; bit changes on the clock's leading edge, 200 ns per bit
	task automatic send_word(input logic [5:0] w, input logic inh, input logic ht);
		int i;
		for (i = 5; i >= 1; i--) begin
			dec_clk_n_out = 1'b0;
			pcm_bit_out = w[i];
			step(4);
			dec_clk_n_out = 1'b1;
			step(4);
		end
		// sixth pulse held low until the transfer is over
		dec_clk_n_out = 1'b0;
		pcm_bit_out = w[0];
		inhibit_n_out = !inh;
		step(4);
		readout_out = 1'b0;
		step(ht ? 14 : 10);
		dec_clk_n_out = 1'b1;
		readout_out = 1'b1;
		inhibit_n_out = 1'b1;
		step(4);
	endtask

	// out of frame: clock stands still, line carries noise
	task automatic frozen_readout();
		in_frame_out = 1'b0;
		step(6);
		// odd count, so a leak would show in the readout word
		repeat (3) begin
			pcm_bit_out = !pcm_bit_out;
			step(3);
		end
		readout_out = 1'b0;
		step(10);
		readout_out = 1'b1;
		// line back to its old level before the frame returns
		pcm_bit_out = !pcm_bit_out;
		step(4);
		in_frame_out = 1'b1;
		step(6);
	endtask
endmodule // pwd_rx_model
`default_nettype wire

// ==== verif/tb_top.sv ====
/*
 * Self-checking bench for the decoder control: words through the
 * serial path, tap FIFO fill and drain, frame freeze.
 * Assumes the bound monitor and the receive section model.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pwd_defines.vh"

module tb_top;
	logic core_clk_in, rst_n_in, variant_select_in, word_ready_in, overrun_clear_in;
	wire logic pcm, dclk_n, frame, rdout, inh_n, word_valid_out, tap_ready_out, overrun_out;
	wire logic [5:0] word_out;
	logic [5:0] exp_q [$];
	logic [5:0] codes [4] = '{6'h0f, 6'h30, 6'h00, 6'h3f};
	logic [5:0] w;
	int failures = 0;
	int comparisons = 0;
	int i, v, seed_word;

	pwd_rx_model rx (.core_clk_in(core_clk_in), .pcm_bit_out(pcm), .dec_clk_n_out(dclk_n),
		.in_frame_out(frame), .readout_out(rdout), .inhibit_n_out(inh_n));
	pwd_decoder_ctrl uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .pcm_bit_in(pcm),
		.dec_clk_n_in(dclk_n), .in_frame_in(frame), .readout_in(rdout), .addr_inhibit_n_in(inh_n),
		.variant_select_in(variant_select_in), .word_ready_in(word_ready_in),
		.overrun_clear_in(overrun_clear_in), .clamp_out(), .clamp_msb_n_out(), .half_dn_out(),
		.half_up_out(), .top_a_out(), .top_a_n_out(), .top_b_out(), .top_b_n_out(),
		.word_rate_timing_out(), .word_valid_out(word_valid_out), .word_out(word_out),
		.tap_ready_out(tap_ready_out), .overrun_out(overrun_out), .in_frame_out());

	initial begin
		core_clk_in = 1'b0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		$display("counts: comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// note the expected tap word, then play the word on the pins
	task automatic send(input logic [5:0] wd, input logic inh, input logic noted);
		if (noted)
			exp_q.push_back(inh ? (wd & 6'h3e) : wd);
		rx.send_word(wd, inh, variant_select_in);
	endtask

	task automatic drain();
		int n;
		for (n = 0; n < 400 && (exp_q.size() != 0 || word_valid_out); n++)
			@(posedge core_clk_in);
		#1;
		if (n == 400) begin
			failures++;
			$display("wrong value drain expected empty seen %0d left", exp_q.size());
			summarize();
		end
	endtask

	////////////////////////////////////////////////////////////////
	// tap watcher: every word taken is matched against the oldest note
	always @(posedge core_clk_in) begin
		if (rst_n_in && word_valid_out && word_ready_in) begin
			if (exp_q.size() == 0) begin
				comparisons++;
				failures++;
				$display("wrong value tap word expected none seen %h", word_out);
			end else
				chk("tap word", exp_q.pop_front(), word_out);
		end
	end

	initial begin
		rst_n_in = 1'b0;
		variant_select_in = 1'b0;
		word_ready_in = 1'b1;
		overrun_clear_in = 1'b0;
		seed_word = $urandom(32'hea4d559f);
		repeat (16) @(posedge core_clk_in);
		#1;
		rst_n_in = 1'b1;
		rx.step(6);
		rx.in_frame_out = 1'b1;
		rx.step(6);
		for (v = 0; v < 2; v++) begin
			variant_select_in = v[0];
			for (i = 0; i < 6; i++)
				send((i < 4) ? codes[i] : 6'($urandom_range(63)), 1'b0, 1'b1);
			send(codes[v == 0 ? 0 : 3], 1'b1, 1'b1);
			send(6'h3f, 1'b1, 1'b1);
		end
		drain();
		$display("test codes and variants done");
		variant_select_in = 1'b0;
		w = 6'($urandom_range(63));
		send(w, 1'b0, 1'b1);
		// sixth shift moved the word up; first stage still holds bit 0
		exp_q.push_back({w[4:0], w[0]});
		rx.frozen_readout();
		drain();
		$display("test frame freeze done");
		word_ready_in = 1'b0;
		for (i = 0; i < 10; i++)
			send(6'($urandom_range(63)), 1'b0, i < 9);
		chk("overrun", 6'h01, {5'h00, overrun_out});
		chk("tap ready full", 6'h00, {5'h00, tap_ready_out});
		overrun_clear_in = 1'b1;
		rx.step(1);
		overrun_clear_in = 1'b0;
		rx.step(1);
		chk("overrun cleared", 6'h00, {5'h00, overrun_out});
		word_ready_in = 1'b1;
		drain();
		chk("tap ready empty", 6'h01, {5'h00, tap_ready_out});
		$display("test tap fill and drain done");
		summarize();
	end
endmodule // tb_top
`default_nettype wire
